// >>> rtl/fph_pkg.sv
// constants for the fsk packet handler and mode sequencer
// assumes a 32-bit apb slave, registers one word each at four times the index
package fph_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register indices, byte address is index times four
    localparam logic [5:0] IDX_FMT  = 6'h30;
    localparam logic [5:0] IDX_MODE = 6'h31;
    localparam logic [5:0] IDX_PLEN = 6'h32;
    localparam logic [5:0] IDX_OWN  = 6'h33;
    localparam logic [5:0] IDX_ALL  = 6'h34;
    localparam logic [5:0] IDX_THR  = 6'h35;
    localparam logic [5:0] IDX_SEQ  = 6'h36;
    localparam logic [5:0] IDX_STAT = 6'h38;
    localparam logic [5:0] IDX_MASK = 6'h39;
    localparam logic [5:0] IDX_SST  = 6'h3A;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int FMT_VAR   = 7;
    localparam int FMT_LBC   = 5;
    localparam int FMT_CRC   = 4;
    localparam int FMT_KEEP  = 3;
    localparam int FMT_ADDR  = 1;
    localparam int FMT_VARNT = 0;
    localparam int MODE_BCN  = 3;
    localparam int THR_SEL   = 7;
    localparam int SEQ_GO    = 7;
    localparam int SEQ_HALT  = 6;
    localparam int SEQ_IDLE  = 5;
    localparam int SEQ_START = 3;
    localparam int SEQ_LP    = 2;
    localparam int SEQ_FIDLE = 1;
    localparam int SEQ_FSEND = 0;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] RST_FMT  = 8'h90;
    localparam logic [6:0] RST_MODE = 7'h40;
    localparam logic [7:0] RST_PLEN = 8'h40;
    localparam logic [7:0] RST_ID   = 8'h00;
    localparam logic [6:0] RST_THR  = 7'h4F;
    localparam logic [5:0] RST_SEQ  = 6'h00;

    ////////////////////////////////////////////////////////////////////////
    // two-bit codes
    localparam logic [1:0] LBC_OFF = 2'h0;
    localparam logic [1:0] LBC_RSV = 2'h3;
    localparam logic [1:0] AM_OWN  = 2'h1;
    localparam logic [1:0] AM_BOTH = 2'h2;
    localparam logic [1:0] GO_LP   = 2'h0;
    localparam logic [1:0] GO_RX   = 2'h1;
    localparam logic [1:0] GO_TX   = 2'h2;
    localparam logic [1:0] GO_LVL  = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // chip modes and interrupt status bits
    localparam logic [2:0] CM_SLEEP   = 3'h0;
    localparam logic [2:0] CM_STANDBY = 3'h1;
    localparam logic [2:0] CM_TX      = 3'h3;
    localparam logic [2:0] CM_RX      = 3'h5;
    localparam int IRQ_W  = 5;
    localparam int IRQ_PD = 0;
    localparam int IRQ_SD = 1;
    localparam int IRQ_LV = 2;
    localparam int IRQ_CF = 3;
    localparam int IRQ_OF = 4;

    typedef enum logic [4:0] {
        st_off    = 5'h01,
        st_idle   = 5'h02,
        st_txwait = 5'h04,
        st_tx     = 5'h08,
        st_rx     = 5'h10
    } fph_seq_t;

endpackage

// >>> rtl/fph_top.sv
// packet handler configuration, address filter, crc outcome and mode sequencer
// assumes an apb master on clk and a modem datapath on the same clock
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module fph_top #(
    parameter int CNT_W = 7
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // modem datapath status
    input  wire logic [CNT_W-1:0] fifo_bytes,
    input  wire logic [2:0]       chip_mode_cur,
    input  wire logic             send_done_irq,
    input  wire logic             first_timer_irq,
    input  wire logic             rx_done,
    input  wire logic             rx_crc_bad,
    input  wire logic             rx_addr_valid,
    input  wire logic [7:0]       rx_addr_byte,
    // framing controls
    output logic                  fmt_variable,
    output logic      [1:0]       line_balance_coding,
    output logic                  checksum_enable,
    output logic                  checksum_scramble_variant,
    output logic                  beacon_enable,
    output logic      [10:0]      payload_size,
    output logic                  addr_ok,
    // receive and send events
    output logic                  payload_done_irq,
    output logic                  fifo_flush,
    output logic                  rx_restart,
    output logic                  queue_level_irq,
    output logic                  tx_go,
    // sequencer
    output logic      [4:0]       seq_state,
    output logic      [2:0]       chip_mode_req,
    output logic                  irq
);

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0]  fmt_r;
    logic [6:0]  mode_r;
    logic [7:0]  plen_r;
    logic [7:0]  own_r;
    logic [7:0]  all_r;
    logic [6:0]  thr_r;
    logic [5:0]  seq_r;
    logic [fph_pkg::IRQ_W-1:0] stat_r;
    logic [fph_pkg::IRQ_W-1:0] mask_r;
    logic [fph_pkg::IRQ_W-1:0] stat_nxt;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [1:0]  lbc_r;
    logic        addr_ok_r;
    logic        pd_r;
    logic        flush_r;
    logic        restart_r;
    logic        lvl_r;
    logic        tx_go_r;
    logic        bcn_r;
    logic        irq_r;
    logic [2:0]  init_mode_r;
    logic [2:0]  init_mode_nxt;
    logic [2:0]  cmode_r;
    logic [2:0]  cmode_nxt;
    fph_pkg::fph_seq_t state_r;
    fph_pkg::fph_seq_t state_nxt;
    fph_pkg::fph_seq_t lp_state;

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    wire [5:0] idx      = paddr[7:2];
    wire       aligned  = (paddr[1:0] == 2'h0);
    wire       acc      = psel & penable;
    wire       setup_ok = acc & ~pready_r;
    wire       done     = acc & pready_r;
    wire       wr       = done & pwrite;
    wire       rd       = done & ~pwrite;
    wire       hit_fmt  = aligned & (idx == fph_pkg::IDX_FMT);
    wire       hit_mode = aligned & (idx == fph_pkg::IDX_MODE);
    wire       hit_plen = aligned & (idx == fph_pkg::IDX_PLEN);
    wire       hit_own  = aligned & (idx == fph_pkg::IDX_OWN);
    wire       hit_all  = aligned & (idx == fph_pkg::IDX_ALL);
    wire       hit_thr  = aligned & (idx == fph_pkg::IDX_THR);
    wire       hit_seq  = aligned & (idx == fph_pkg::IDX_SEQ);
    wire       hit_stat = aligned & (idx == fph_pkg::IDX_STAT);
    wire       hit_mask = aligned & (idx == fph_pkg::IDX_MASK);
    wire       hit_sst  = aligned & (idx == fph_pkg::IDX_SST);
    wire       mapped   = hit_fmt | hit_mode | hit_plen | hit_own | hit_all
                        | hit_thr | hit_seq | hit_stat | hit_mask | hit_sst;
    wire [31:0] rd_val  = hit_fmt  ? {24'h0, fmt_r} :
                          hit_mode ? {25'h0, mode_r} :
                          hit_plen ? {24'h0, plen_r} :
                          hit_own  ? {24'h0, own_r} :
                          hit_all  ? {24'h0, all_r} :
                          hit_thr  ? {24'h0, thr_r[6], 1'b0, thr_r[5:0]} :
                          hit_seq  ? {26'h0, seq_r} :
                          hit_stat ? {27'h0, stat_r} :
                          hit_mask ? {27'h0, mask_r} :
                          hit_sst  ? {24'h0, cmode_r, state_r} : 32'h0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end else begin
            pready_r  <= setup_ok;
            pslverr_r <= setup_ok & ~mapped;
            prdata_r  <= (setup_ok & ~pwrite) ? rd_val : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration storage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fmt_r  <= fph_pkg::RST_FMT;
            mode_r <= fph_pkg::RST_MODE;
            plen_r <= fph_pkg::RST_PLEN;
            own_r  <= fph_pkg::RST_ID;
            all_r  <= fph_pkg::RST_ID;
            thr_r  <= fph_pkg::RST_THR;
            seq_r  <= fph_pkg::RST_SEQ;
            mask_r <= '0;
        end else if (wr) begin
            if (hit_fmt)  fmt_r  <= pwdata[7:0];
            if (hit_mode) mode_r <= pwdata[6:0];
            if (hit_plen) plen_r <= pwdata[7:0];
            if (hit_own)  own_r  <= pwdata[7:0];
            if (hit_all)  all_r  <= pwdata[7:0];
            if (hit_thr)  thr_r  <= {pwdata[fph_pkg::THR_SEL], pwdata[5:0]};
            if (hit_seq)  seq_r  <= pwdata[5:0];
            if (hit_mask) mask_r <= pwdata[fph_pkg::IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // field views
    wire        f_var   = fmt_r[fph_pkg::FMT_VAR];
    wire [1:0]  f_lbc   = fmt_r[fph_pkg::FMT_LBC+:2];
    wire        f_crc   = fmt_r[fph_pkg::FMT_CRC];
    wire        f_keep  = fmt_r[fph_pkg::FMT_KEEP];
    wire [1:0]  f_am    = fmt_r[fph_pkg::FMT_ADDR+:2];
    wire        f_trig  = thr_r[6];
    wire [CNT_W:0] mark1 = {{(CNT_W-5){1'b0}}, thr_r[5:0]} + 1'b1;
    wire [CNT_W:0] cnt  = {1'b0, fifo_bytes};
    wire        lvl_now = (cnt >= mark1);
    wire        any_b   = (fifo_bytes != '0);
    wire        over    = (cnt > (mark1 - 1'b1));
    wire        trig_ok = f_trig ? any_b : over;
    wire        own_eq  = (rx_addr_byte == own_r);
    wire        all_eq  = (rx_addr_byte == all_r);
    wire        am_ok   = (f_am == fph_pkg::AM_OWN)  ? own_eq :
                          (f_am == fph_pkg::AM_BOTH) ? (own_eq | all_eq) : 1'b1;
    wire        crc_bad = f_crc & rx_crc_bad;
    wire        cf_evt  = rx_done & crc_bad;
    wire        pd_evt  = rx_done & (~crc_bad | f_keep);

    ////////////////////////////////////////////////////////////////////////
    // datapath controls
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lbc_r     <= fph_pkg::LBC_OFF;
            addr_ok_r <= 1'b1;
            pd_r      <= 1'b0;
            flush_r   <= 1'b0;
            restart_r <= 1'b0;
            lvl_r     <= 1'b0;
            tx_go_r   <= 1'b0;
            bcn_r     <= 1'b0;
        end else begin
            lbc_r     <= (f_lbc == fph_pkg::LBC_RSV) ? fph_pkg::LBC_OFF : f_lbc;
            addr_ok_r <= rx_addr_valid ? am_ok : addr_ok_r;
            pd_r      <= pd_evt;
            flush_r   <= cf_evt & ~f_keep;
            restart_r <= cf_evt & ~f_keep;
            lvl_r     <= lvl_now;
            tx_go_r   <= (state_r == fph_pkg::st_tx) & trig_ok;
            bcn_r     <= mode_r[fph_pkg::MODE_BCN] & ~f_var;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    wire go_wr   = wr & hit_seq & pwdata[fph_pkg::SEQ_GO];
    wire halt_wr = wr & hit_seq & pwdata[fph_pkg::SEQ_HALT];
    wire mode_ok = (chip_mode_cur == fph_pkg::CM_SLEEP) | (chip_mode_cur == fph_pkg::CM_STANDBY);
    // route fields written together with go steer that same start
    wire [5:0] seq_v   = (wr & hit_seq) ? pwdata[5:0] : seq_r;
    wire [1:0] s_start = seq_v[fph_pkg::SEQ_START+:2];

    assign lp_state = seq_v[fph_pkg::SEQ_LP] ? fph_pkg::st_idle : fph_pkg::st_off;

    always_comb begin
        state_nxt     = state_r;
        init_mode_nxt = init_mode_r;
        if (halt_wr) begin
            state_nxt = fph_pkg::st_off;
        end else begin
            case (state_r)
                fph_pkg::st_off: begin
                    if (go_wr & mode_ok) begin
                        init_mode_nxt = chip_mode_cur;
                        case (s_start)
                            fph_pkg::GO_LP:  state_nxt = lp_state;
                            fph_pkg::GO_RX:  state_nxt = fph_pkg::st_rx;
                            fph_pkg::GO_TX:  state_nxt = fph_pkg::st_tx;
                            default:         state_nxt = fph_pkg::st_txwait;
                        endcase
                    end
                end
                fph_pkg::st_idle: begin
                    if (first_timer_irq) begin
                        state_nxt = seq_v[fph_pkg::SEQ_FIDLE] ? fph_pkg::st_rx : fph_pkg::st_tx;
                    end
                end
                fph_pkg::st_txwait: begin
                    if (lvl_r) begin
                        state_nxt = fph_pkg::st_tx;
                    end
                end
                fph_pkg::st_tx: begin
                    if (send_done_irq) begin
                        state_nxt = seq_v[fph_pkg::SEQ_FSEND] ? fph_pkg::st_rx : lp_state;
                    end
                end
                fph_pkg::st_rx: begin
                    state_nxt = fph_pkg::st_rx;
                end
                default: begin
                    state_nxt = fph_pkg::st_off;
                end
            endcase
        end
    end

    always_comb begin
        case (state_nxt)
            fph_pkg::st_idle: cmode_nxt = seq_v[fph_pkg::SEQ_IDLE] ? fph_pkg::CM_SLEEP
                                                                   : fph_pkg::CM_STANDBY;
            fph_pkg::st_tx:   cmode_nxt = fph_pkg::CM_TX;
            fph_pkg::st_rx:   cmode_nxt = fph_pkg::CM_RX;
            default:          cmode_nxt = init_mode_nxt;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r     <= fph_pkg::st_off;
            init_mode_r <= fph_pkg::CM_STANDBY;
            cmode_r     <= fph_pkg::CM_STANDBY;
        end else begin
            state_r     <= state_nxt;
            init_mode_r <= init_mode_nxt;
            cmode_r     <= cmode_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts, set wins over the read clear
    wire off_evt = (state_r != fph_pkg::st_off) & (state_nxt == fph_pkg::st_off);
    wire lv_evt  = lvl_now & ~lvl_r;
    wire [fph_pkg::IRQ_W-1:0] set_v = {off_evt, cf_evt, lv_evt, send_done_irq, pd_evt};
    wire [fph_pkg::IRQ_W-1:0] clr_v = (rd & hit_stat) ? '1 : '0;

    assign stat_nxt = (stat_r & ~clr_v) | set_v;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stat_r <= '0;
            irq_r  <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            irq_r  <= |(stat_nxt & mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign prdata                    = prdata_r;
    assign pready                    = pready_r;
    assign pslverr                   = pslverr_r;
    assign fmt_variable              = fmt_r[fph_pkg::FMT_VAR];
    assign line_balance_coding       = lbc_r;
    assign checksum_enable           = fmt_r[fph_pkg::FMT_CRC];
    assign checksum_scramble_variant = fmt_r[fph_pkg::FMT_VARNT];
    assign beacon_enable             = bcn_r;
    assign payload_size              = {mode_r[2:0], plen_r};
    assign addr_ok                   = addr_ok_r;
    assign payload_done_irq          = pd_r;
    assign fifo_flush                = flush_r;
    assign rx_restart                = restart_r;
    assign queue_level_irq           = lvl_r;
    assign tx_go                     = tx_go_r;
    assign seq_state                 = state_r;
    assign chip_mode_req             = cmode_r;
    assign irq                       = irq_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_halt_off: assert property (@(posedge clk) disable iff (rst)
        halt_wr |=> (state_r == fph_pkg::st_off))
        else $error("halt did not stop sequencer");

    chk_halt_reads_zero: assert property (@(posedge clk) disable iff (rst)
        (rd & hit_seq) |-> (prdata_r[fph_pkg::SEQ_HALT] == 1'b0) && (prdata_r[fph_pkg::SEQ_GO] == 1'b0))
        else $error("go or halt read back set");

    chk_level_mark: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> (lvl_r == ({1'b0, $past(fifo_bytes)} > {2'b00, $past(thr_r[5:0])})))
        else $error("level flag wrong");

    chk_fail_flush: assert property (@(posedge clk) disable iff (rst)
        (rx_done & f_crc & rx_crc_bad & ~f_keep) |=> (flush_r & restart_r & ~pd_r))
        else $error("crc fail not flushed");

    chk_fail_keep: assert property (@(posedge clk) disable iff (rst)
        (rx_done & f_crc & rx_crc_bad & f_keep) |=> (pd_r & ~flush_r))
        else $error("kept packet not signalled");

    chk_go_route: assert property (@(posedge clk) disable iff (rst)
        (go_wr & ~halt_wr & mode_ok & (state_r == fph_pkg::st_off) & (s_start == fph_pkg::GO_TX))
        |=> (state_r == fph_pkg::st_tx) && (cmode_r == fph_pkg::CM_TX))
        else $error("start route to send failed");

    chk_go_refused: assert property (@(posedge clk) disable iff (rst)
        (go_wr & ~mode_ok & (state_r == fph_pkg::st_off)) |=> (state_r == fph_pkg::st_off))
        else $error("go accepted in wrong mode");

    chk_idle_timer: assert property (@(posedge clk) disable iff (rst)
        ((state_r == fph_pkg::st_idle) & first_timer_irq & ~halt_wr & ~seq_v[fph_pkg::SEQ_FIDLE])
        |=> (state_r == fph_pkg::st_tx))
        else $error("idle timer route wrong");

    chk_send_done: assert property (@(posedge clk) disable iff (rst)
        ((state_r == fph_pkg::st_tx) & send_done_irq & ~halt_wr & seq_v[fph_pkg::SEQ_FSEND])
        |=> (state_r == fph_pkg::st_rx))
        else $error("send done route wrong");

    chk_addr_own: assert property (@(posedge clk) disable iff (rst)
        (rx_addr_valid & (f_am == fph_pkg::AM_OWN)) |=> (addr_ok_r == $past(own_eq)))
        else $error("own address filter wrong");

    chk_idle_power: assert property (@(posedge clk) disable iff (rst)
        $changed(state_r) && (state_r == fph_pkg::st_idle)
        |-> (cmode_r == ($past(seq_v[fph_pkg::SEQ_IDLE]) ? fph_pkg::CM_SLEEP : fph_pkg::CM_STANDBY)))
        else $error("idle power mode wrong");

    chk_beacon_fixed: assert property (@(posedge clk) disable iff (rst)
        bcn_r |-> $past(~f_var))
        else $error("beacon active in variable format");

endmodule // fph_top

`default_nettype wire

// >>> testbench/fph_far_model.sv
// far side model: chip mode follows the request, a send completes a while after tx_go
// assumes the same clock and reset as fph_top
`timescale 1ns/100ps
`default_nettype none
module fph_far_model #(
    parameter int DLY = 6
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // link
    input  wire logic [2:0] chip_mode_req,
    input  wire logic       tx_go,
    output logic      [2:0] chip_mode_cur,
    output logic            send_done_irq
);
    int cnt_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chip_mode_cur <= 3'h1;
            send_done_irq <= 1'b0;
            cnt_r         <= 0;
        end else begin
            chip_mode_cur <= chip_mode_req;
            send_done_irq <= (cnt_r == DLY);
            cnt_r         <= tx_go ? cnt_r + 1 : 0;
        end
    end
endmodule // fph_far_model
`default_nettype wire

// >>> testbench/testbench.sv
// bench for fph_top: registers, filter, crc outcome, level and sequencer
// assumes fph_pkg and fph_far_model compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, rxd, cb, av, tmr, sd, e;
    logic fv, ce, cv, be, ok, pd, ff, rr, ql, tg, irq;
    logic [31:0] pw, pr, r, d;
    logic [7:0]  pa, ab, o, b, x;
    logic [6:0]  fb;
    logic [5:0]  m;
    logic [4:0]  st;
    logic [2:0]  cm, mr;
    logic [1:0]  lb;
    logic [10:0] ps;
    logic [7:0]  rv[7] = '{8'h90, 8'h40, 8'h40, 8'h00, 8'h00, 8'h8F, 8'h00};
    logic [4:0]  rs[4] = '{5'h01, 5'h10, 5'h08, 5'h04};
    int bad_count = 0;
    int samples_checked = 0;
    fph_top uut (.clk, .rst, .psel, .penable, .pwrite, .paddr(pa), .pwdata(pw), .prdata(pr), .pready,
        .pslverr, .fifo_bytes(fb), .chip_mode_cur(cm), .send_done_irq(sd), .first_timer_irq(tmr),
        .rx_done(rxd), .rx_crc_bad(cb), .rx_addr_valid(av), .rx_addr_byte(ab), .fmt_variable(fv),
        .line_balance_coding(lb), .checksum_enable(ce), .checksum_scramble_variant(cv),
        .beacon_enable(be), .payload_size(ps), .addr_ok(ok), .payload_done_irq(pd), .fifo_flush(ff),
        .rx_restart(rr), .queue_level_irq(ql), .tx_go(tg), .seq_state(st), .chip_mode_req(mr), .irq);
    fph_far_model #(.DLY(6)) far (.clk, .rst, .chip_mode_req(mr), .tx_go(tg), .chip_mode_cur(cm),
        .send_done_irq(sd));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string n, input logic [31:0] xv, input logic [31:0] g);
        samples_checked++;
        if (g !== xv) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, xv, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dv);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        pa <= a;
        pw <= dv;
        cyc(1);
        penable <= 1'b1;
        do begin
            cyc(1);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("pready", 1, pready);
        r = pr;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        cyc(1);
    endtask
    task automatic wst(input logic [4:0] xs);
        int n;
        n = 0;
        while (st !== xs && n < 12) begin
            cyc(1);
            n++;
        end
        chk("seq_state", xs, st);
    endtask
    function automatic logic amx(input logic [1:0] md, input logic [7:0] a, input logic [7:0] on,
                                 input logic [7:0] al);
        return md == 2'h1 ? a == on : md == 2'h2 ? (a == on || a == al) : 1'b1;
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        cyc(20000);
        bad_count++;
        print_verdict();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, psel, penable, pwrite, rxd, cb, av, tmr} = '0;
        {pa, pw, ab, fb} = '0;
        rst = 1'b1;
        d = $urandom(32'h84D6);
        cyc(2);
        rst <= 1'b0;
        cyc(1);
        chk("fmt_variable", 1, fv);
        chk("payload_size", 32'h40, ps);
        for (int i = 0; i < 7; i++) begin
            apb(0, 8'hC0 + 8'(4 * i), 0);
            chk("reset value", rv[i], r);
        end
        apb(0, 8'hFC, 0);
        chk("unmapped", 32'h80000000, {e, r[30:0]});
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            d = $urandom;
            d[6:5] = i[1:0];
            apb(1, 8'hC0, d);
            apb(0, 8'hC0, 0);
            chk("fmt", d[7:0], r);
            chk("coding", d[6:5] == 2'h3 ? 2'h0 : d[6:5], lb);
            chk("crc", {d[4], d[0]}, {ce, cv});
            chk("format", d[7], fv);
            apb(1, 8'hC4, d);
            apb(1, 8'hC8, d >> 8);
            chk("beacon", d[3] && !d[7], be);
            chk("size", {d[2:0], d[15:8]}, ps);
        end
        $display("format test done");
        o = $urandom;
        b = o ^ 8'h3C;
        apb(1, 8'hCC, o);
        apb(1, 8'hD0, b);
        for (int k = 0; k < 12; k++) begin
            x = k % 3 == 0 ? o : k % 3 == 1 ? b : o ^ 8'hC3;
            apb(1, 8'hC0, 32'(k / 3) << 1);
            av <= 1'b1;
            ab <= x;
            cyc(1);
            av <= 1'b0;
            cyc(1);
            chk("addr_ok", amx(2'(k / 3), x, o, b), ok);
        end
        $display("filter test done");
        apb(1, 8'hE4, 32'h1);
        for (int k = 0; k < 4; k++) begin
            apb(1, 8'hC0, 32'h10 | (k[1] << 3));
            apb(0, 8'hE0, 0);
            cb <= k[0];
            rxd <= 1'b1;
            cyc(1);
            rxd <= 1'b0;
            cyc(1);
            chk("done", !k[0] || k[1], pd);
            chk("flush", {2{k[0] && !k[1]}}, {ff, rr});
            cyc(2);
            chk("irq", !k[0] || k[1], irq);
            apb(0, 8'hE0, 0);
            chk("status", !k[0] || k[1], r[0]);
            chk("irq clear", 0, irq);
        end
        $display("crc test done");
        for (int k = 0; k < 4; k++) begin
            m = k == 0 ? 6'h0 : k == 1 ? 6'h3F : 6'($urandom % 63);
            apb(1, 8'hD4, {k[0], 1'b0, m});
            fb <= 7'(m);
            cyc(2);
            chk("level low", 0, ql);
            fb <= 7'(m) + 7'h1;
            cyc(2);
            chk("level high", 1, ql);
        end
        fb <= 7'h0;
        $display("level test done");
        for (int k = 0; k < 4; k++) begin
            apb(1, 8'hD8, 32'h40);
            apb(1, 8'hD8, 32'h80 | (k << 3));
            wst(rs[k]);
        end
        fb <= 7'h40;
        wst(5'h08);
        apb(1, 8'hD8, 32'h40);
        wst(5'h01);
        chk("initial mode", 3'h1, mr);
        fb <= 7'h5;
        apb(1, 8'hD4, 32'h05);
        apb(1, 8'hD8, 32'h90);
        wst(5'h08);
        cyc(2);
        chk("tx_go low", 0, tg);
        fb <= 7'h6;
        cyc(2);
        chk("tx_go high", 1, tg);
        apb(1, 8'hD8, 32'h40);
        fb <= 7'h0;
        apb(1, 8'hD4, 32'h80);
        apb(1, 8'hD8, 32'hB6);
        wst(5'h08);
        chk("tx mode", 3'h3, mr);
        fb <= 7'h1;
        cyc(2);
        chk("tx_go any", 1, tg);
        wst(5'h02);
        chk("idle mode", 3'h0, mr);
        tmr <= 1'b1;
        cyc(1);
        tmr <= 1'b0;
        wst(5'h10);
        chk("rx mode", 3'h5, mr);
        apb(1, 8'hD8, 32'hB6);
        wst(5'h10);
        apb(0, 8'hD8, 0);
        chk("seq readback", 32'h36, r);
        apb(1, 8'hD8, 32'h40);
        wst(5'h01);
        apb(1, 8'hD8, 32'h91);
        wst(5'h08);
        wst(5'h10);
        apb(1, 8'hD8, 32'h40);
        apb(1, 8'hD8, 32'h84);
        wst(5'h02);
        chk("standby idle", 3'h1, mr);
        tmr <= 1'b1;
        cyc(1);
        tmr <= 1'b0;
        wst(5'h08);
        apb(1, 8'hD8, 32'h40);
        wst(5'h01);
        $display("sequencer test done");
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
